// *** rtl/opmode_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_SYSCLK_CONTROL 4'h0
`define ADDR_HS_OSC_CONTROL 4'h1
`define ADDR_MODE_STATUS 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_CLEAR 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_HALT_CMD 4'h6
`define ADDR_WAKE_CMD 4'h7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEL_HI 7
`define SEL_LO 5
`define HS_KEEP_BIT 1
`define LS_KEEP_BIT 0
`define HS_STABLE_BIT 1
`define HS_ENABLE_BIT 0
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SEL_RESET 3'h0
`define SEL_LOWSPEED 3'h7
`define HS_ENABLE_RESET 1'h1
`define IRQ_BITS 3
// ----------------------------------------------------------------
// timing: oscillator start times in ns
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 20
`define HS_START_NS 16000
`define LS_START_NS 2000
`endif

// *** rtl/opmode_pkg.sv ***
// types shared by the operating mode clock controller
package opmode_pkg;
  // operating mode, one-hot
  typedef enum logic [5:0] {
    mode_fast = 6'b00_0001,
    mode_slow = 6'b00_0010,
    mode_sleep = 6'b00_0100,
    mode_idle_lowspeed_only = 6'b00_1000,
    mode_idle_both_clocks = 6'b01_0000,
    mode_idle_highspeed_only = 6'b10_0000
  } op_mode_e;
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } bus_req_s;
  // clock gates towards the chip
  typedef struct packed {
    logic cpu_run;
    logic sys_clk_run;
    logic hs_osc_on;
    logic ls_osc_on;
    logic [2:0] sysclk_select;
  } clk_gate_s;
endpackage

// *** rtl/operating_mode_clock_controller.sv ***
// operating mode and oscillator control with register port
//
// Implementation choices: the register offsets and strobed register access.
`include "opmode_defines.svh"
module operating_mode_clock_controller
  import opmode_pkg::*;
#(
  parameter int HS_START_NS = `HS_START_NS,
  parameter int LS_START_NS = `LS_START_NS,
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire bus_req_s bus_req,
  output logic [7:0] rdata,
  output clk_gate_s clk_gate,
  output op_mode_e op_mode,
  output logic powerdown_flag,
  output logic watchdog_timeout_flag,
  output logic watchdog_clear,
  output logic irq
);
  // ----------------------------------------------------------------
  // derived counts (least times round up)
  // ----------------------------------------------------------------
  localparam int HS_CYC_I = (HS_START_NS + `CLOCK_PERIOD_NS - 1)
                            / `CLOCK_PERIOD_NS;
  localparam int LS_CYC_I = (LS_START_NS + `CLOCK_PERIOD_NS - 1)
                            / `CLOCK_PERIOD_NS;
  localparam logic [CNT_W-1:0] HS_CYC = CNT_W'(HS_CYC_I);
  localparam logic [CNT_W-1:0] LS_CYC = CNT_W'(LS_CYC_I);
  // refuse counts that do not fit the counter
  if (CNT_W < 2 || CNT_W > 30) begin : g_bad_width
    $error("counter width out of range");
  end
  if (HS_CYC_I >= (1 << CNT_W) || LS_CYC_I >= (1 << CNT_W)
      || HS_CYC_I < 1 || LS_CYC_I < 1) begin : g_bad_count
    $error("start counts do not fit the counter width");
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] sel_reg; // system clock select
  logic hs_keep_reg; // high-speed keep-on in halt
  logic ls_keep_reg; // low-speed keep-on in halt
  logic hs_en_reg; // high-speed oscillator enable
  logic hs_stable_reg; // high-speed stable flag
  logic ls_stable_reg; // low-speed stable flag
  logic [CNT_W-1:0] hs_cnt_reg; // high-speed start counter
  logic [CNT_W-1:0] ls_cnt_reg; // low-speed start counter
  logic [2:0] act_sel_reg; // select actually in force
  op_mode_e mode_reg; // current operating mode
  logic pdf_reg; // power-down flag
  logic to_reg; // watchdog timeout flag
  logic wdt_clr_reg; // watchdog counter clear pulse
  logic [`IRQ_BITS-1:0] ist_reg; // sticky events
  logic [`IRQ_BITS-1:0] ien_reg; // event enables
  logic irq_reg; // interrupt output
  logic [7:0] rdata_reg; // read data
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_scc = bus_req.write && bus_req.addr == `ADDR_SYSCLK_CONTROL;
  wire wr_hsc = bus_req.write && bus_req.addr == `ADDR_HS_OSC_CONTROL;
  wire wr_iclr = bus_req.write && bus_req.addr == `ADDR_IRQ_CLEAR;
  wire wr_ien = bus_req.write && bus_req.addr == `ADDR_IRQ_ENABLE;
  wire halt_cmd = bus_req.write && bus_req.addr == `ADDR_HALT_CMD;
  wire wake_cmd = bus_req.write && bus_req.addr == `ADDR_WAKE_CMD;
  // processor is running in fast or slow mode
  wire running = mode_reg == mode_fast || mode_reg == mode_slow;
  // halt only taken while running
  wire halt_go = halt_cmd && running;
  // ----------------------------------------------------------------
  // oscillator needs
  // ----------------------------------------------------------------
  // high-speed wanted while running if enabled or a fast select is requested, or in halt when kept on
  wire hs_need = running ? hs_en_reg || sel_reg != `SEL_LOWSPEED
                         : hs_keep_reg;
  // low-speed always runs except in halt without keep-on
  wire ls_need = running || ls_keep_reg;
  // fresh enable write restarts the stable wait
  wire hs_restart = wr_hsc && bus_req.wdata[`HS_ENABLE_BIT]
                    && !hs_en_reg;
  wire hs_cnt_done = hs_cnt_reg == HS_CYC;
  wire ls_cnt_done = ls_cnt_reg == LS_CYC;
  // pending switch may complete when its source is stable
  wire sel_to_slow = sel_reg == `SEL_LOWSPEED;
  wire switch_ok = sel_to_slow ? ls_stable_reg
                               : hs_stable_reg;
  // mode chosen by halt from keep-on bits
  op_mode_e halt_mode;
  always_comb begin
    case ({hs_keep_reg, ls_keep_reg})
      2'b00: halt_mode = mode_sleep;
      2'b01: halt_mode = mode_idle_lowspeed_only;
      2'b11: halt_mode = mode_idle_both_clocks;
      default: halt_mode = mode_idle_highspeed_only;
    endcase
  end
  // events: halt entry, high-speed stable, switch done
  // a switch held off by a halt in the same cycle is not reported
  wire switch_done = running && !halt_go && act_sel_reg != sel_reg
                     && switch_ok;
  wire hs_rise = hs_need && !hs_restart && !hs_stable_reg && hs_cnt_done;
  wire [`IRQ_BITS-1:0] ev = {switch_done, hs_rise, halt_go};
  // read multiplexer
  wire [7:0] rd_scc = {sel_reg, 3'h0, hs_keep_reg, ls_keep_reg};
  wire [7:0] rd_hsc = {6'h00, hs_stable_reg, hs_en_reg};
  wire [7:0] rd_mode = {act_sel_reg, to_reg, pdf_reg,
                        ls_stable_reg, hs_stable_reg, running};
  wire [7:0] rd_ist = {5'h00, ist_reg};
  wire [7:0] rd_ien = {5'h00, ien_reg};
  wire [7:0] rd_mux = bus_req.addr == `ADDR_SYSCLK_CONTROL ? rd_scc
                    : bus_req.addr == `ADDR_HS_OSC_CONTROL ? rd_hsc
                    : bus_req.addr == `ADDR_MODE_STATUS ? rd_mode
                    : bus_req.addr == `ADDR_IRQ_STATUS ? rd_ist
                    : bus_req.addr == `ADDR_IRQ_ENABLE ? rd_ien
                    : 8'h00;
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // clock control and oscillator enable writes
  always_ff @(posedge clock) begin
    if (reset) begin
      sel_reg <= `SEL_RESET;
      hs_keep_reg <= 1'b0;
      ls_keep_reg <= 1'b0;
      hs_en_reg <= `HS_ENABLE_RESET;
    end else begin
      if (wr_scc) begin
        sel_reg <= bus_req.wdata[`SEL_HI:`SEL_LO];
        hs_keep_reg <= bus_req.wdata[`HS_KEEP_BIT];
        ls_keep_reg <= bus_req.wdata[`LS_KEEP_BIT];
      end
      if (wr_hsc) begin
        hs_en_reg <= bus_req.wdata[`HS_ENABLE_BIT];
      end
    end
  end
  // ----------------------------------------------------------------
  // oscillator start models
  // ----------------------------------------------------------------
  // high-speed start counter and stable flag
  always_ff @(posedge clock) begin
    if (reset) begin
      hs_cnt_reg <= '0;
      hs_stable_reg <= 1'b0;
    end else if (!hs_need || hs_restart) begin
      hs_cnt_reg <= '0;
      hs_stable_reg <= 1'b0;
    end else if (!hs_cnt_done) begin
      hs_cnt_reg <= hs_cnt_reg + CNT_W'(1);
    end else begin
      hs_stable_reg <= 1'b1;
    end
  end
  // low-speed start counter and stable flag
  always_ff @(posedge clock) begin
    if (reset) begin
      ls_cnt_reg <= '0;
      ls_stable_reg <= 1'b0;
    end else if (!ls_need) begin
      ls_cnt_reg <= '0;
      ls_stable_reg <= 1'b0;
    end else if (!ls_cnt_done) begin
      ls_cnt_reg <= ls_cnt_reg + CNT_W'(1);
    end else begin
      ls_stable_reg <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // operating mode machine
  // ----------------------------------------------------------------
  // select in force follows the request once source is stable
  always_ff @(posedge clock) begin
    if (reset) begin
      act_sel_reg <= `SEL_RESET;
      mode_reg <= mode_fast;
    end else begin
      case (mode_reg)
        mode_fast, mode_slow: begin
          if (halt_go) begin
            mode_reg <= halt_mode;
          end else if (switch_done) begin
            act_sel_reg <= sel_reg;
            mode_reg <= sel_to_slow ? mode_slow : mode_fast;
          end
        end
        default: begin
          if (wake_cmd) begin
            mode_reg <= act_sel_reg == `SEL_LOWSPEED ? mode_slow
                                                     : mode_fast;
          end
        end
      endcase
    end
  end
  // power-down, timeout and watchdog clear on halt entry
  always_ff @(posedge clock) begin
    if (reset) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
    end else begin
      wdt_clr_reg <= halt_go;
      if (halt_go) begin
        pdf_reg <= 1'b1;
        to_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // interrupts and read data
  // ----------------------------------------------------------------
  // sticky events, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      ist_reg <= '0;
      ien_reg <= '0;
      irq_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ist_reg <= (ist_reg & ~(wr_iclr ? bus_req.wdata[`IRQ_BITS-1:0]
                                      : '0)) | ev;
      if (wr_ien) begin
        ien_reg <= bus_req.wdata[`IRQ_BITS-1:0];
      end
      irq_reg <= |(ist_reg & ien_reg);
      rdata_reg <= bus_req.read ? rd_mux : 8'h00;
    end
  end
  // ----------------------------------------------------------------
  // clock gate outputs, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      clk_gate <= '0;
    end else begin
      clk_gate.cpu_run <= running && !halt_go;
      clk_gate.sys_clk_run <= running && !halt_go;
      clk_gate.hs_osc_on <= hs_need;
      clk_gate.ls_osc_on <= ls_need;
      clk_gate.sysclk_select <= act_sel_reg;
    end
  end
  assign rdata = rdata_reg;
  assign op_mode = mode_reg;
  assign powerdown_flag = pdf_reg;
  assign watchdog_timeout_flag = to_reg;
  assign watchdog_clear = wdt_clr_reg;
  assign irq = irq_reg;
  // ----------------------------------------------------------------
  // checks: halt entry
  // ----------------------------------------------------------------
  // halt entry sets power-down, clears timeout, pulses clear
  halt_sets_pdf_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go |=> pdf_reg && !to_reg && wdt_clr_reg)
    else $error("halt entry flags wrong");
  // both keep-on bits low gives sleep
  sleep_entry_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go && !hs_keep_reg && !ls_keep_reg |=> mode_reg == mode_sleep)
    else $error("sleep not entered");
  // low-speed keep-on only
  idle_ls_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go && !hs_keep_reg && ls_keep_reg
    |=> mode_reg == mode_idle_lowspeed_only)
    else $error("low-speed idle not entered");
  // both keep-on bits high
  idle_both_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go && hs_keep_reg && ls_keep_reg
    |=> mode_reg == mode_idle_both_clocks)
    else $error("both-clock idle not entered");
  // high-speed keep-on only
  idle_hs_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go && hs_keep_reg && !ls_keep_reg
    |=> mode_reg == mode_idle_highspeed_only)
    else $error("high-speed idle not entered");
  // processor clock gate drops at once and stays down for the two cycles after halt entry
  halt_stops_cpu_a: assert property (
    @(posedge clock) disable iff (reset)
    halt_go |=> !clk_gate.cpu_run [*2])
    else $error("processor clock runs after halt");
  // watchdog clear is a single-cycle pulse
  wdt_pulse_a: assert property (
    @(posedge clock) disable iff (reset)
    wdt_clr_reg |=> !wdt_clr_reg)
    else $error("watchdog clear longer than one cycle");
  // halted mode holds until a wake command
  halted_hold_a: assert property (
    @(posedge clock) disable iff (reset)
    !running && !wake_cmd |=> mode_reg == $past(mode_reg))
    else $error("halted mode left without wake");
  // oscillator gates follow the keep-on bits while halted
  idle_gates_a: assert property (
    @(posedge clock) disable iff (reset)
    !running |=> clk_gate.hs_osc_on == $past(hs_keep_reg)
                 && clk_gate.ls_osc_on == $past(ls_keep_reg))
    else $error("oscillator gates wrong in halt");
  // processor and system clock gates stay off while halted
  halt_gates_off_a: assert property (
    @(posedge clock) disable iff (reset)
    !running |=> !clk_gate.cpu_run && !clk_gate.sys_clk_run)
    else $error("clock gate on while halted");
  // ----------------------------------------------------------------
  // checks: oscillators and switching
  // ----------------------------------------------------------------
  // fresh enable drops the stable flag
  restart_clears_a: assert property (
    @(posedge clock) disable iff (reset)
    hs_restart |=> !hs_stable_reg)
    else $error("stable flag not cleared on enable");
  // stable flag rises only after the start count
  stable_late_a: assert property (
    @(posedge clock) disable iff (reset)
    $rose(hs_stable_reg) |-> $past(hs_cnt_done) && $past(hs_need))
    else $error("stable flag rose before start time");
  // flag stays low while the oscillator is unneeded
  unneeded_flag_a: assert property (
    @(posedge clock) disable iff (reset)
    !hs_need |=> !hs_stable_reg)
    else $error("stable flag set while oscillator unneeded");
  // slow select only takes effect on a stable low-speed source
  slow_needs_ls_a: assert property (
    @(posedge clock) disable iff (reset)
    $changed(act_sel_reg) && act_sel_reg == `SEL_LOWSPEED
    |-> $past(ls_stable_reg))
    else $error("slow switch before low-speed stable");
  // running mode agrees with the select in force
  mode_matches_sel_a: assert property (
    @(posedge clock) disable iff (reset)
    running |-> (mode_reg == mode_slow) == (act_sel_reg == `SEL_LOWSPEED))
    else $error("mode and select in force disagree");
  // select gate trails the select in force by one cycle
  gate_follows_sel_a: assert property (
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> clk_gate.sysclk_select == $past(act_sel_reg))
    else $error("select gate does not follow select in force");
  // ----------------------------------------------------------------
  // checks: register reads and reset
  // ----------------------------------------------------------------
  // oscillator control reads flag, enable and zero padding
  read_hsc_a: assert property (
    @(posedge clock) disable iff (reset)
    bus_req.read && bus_req.addr == `ADDR_HS_OSC_CONTROL
    |=> rdata_reg == {6'h00, $past(hs_stable_reg), $past(hs_en_reg)})
    else $error("oscillator control read wrong");
  // clock control reads select and keep-on bits
  read_scc_a: assert property (
    @(posedge clock) disable iff (reset)
    bus_req.read && bus_req.addr == `ADDR_SYSCLK_CONTROL
    |=> rdata_reg == {$past(sel_reg), 3'h0, $past(hs_keep_reg),
                      $past(ls_keep_reg)})
    else $error("clock control read wrong");
  // control fields come out of reset at their reset values
  reset_values_a: assert property (
    @(posedge clock)
    reset |=> sel_reg == `SEL_RESET && !hs_keep_reg && !ls_keep_reg
              && hs_en_reg == `HS_ENABLE_RESET && !hs_stable_reg)
    else $error("control fields not at reset values");
endmodule

// *** tb/operating_mode_clock_controller_tb_top.sv ***
// self-checking bench for the operating mode clock controller
`include "opmode_defines.svh"
module operating_mode_clock_controller_tb_top
  import opmode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock; // 50 MHz system clock
  logic reset; // synchronous, active high
  bus_req_s bus_req; // register port request
  logic [7:0] rdata; // read data, cycle after strobe
  clk_gate_s clk_gate; // clock gates
  op_mode_e op_mode; // one-hot mode
  logic powerdown_flag;
  logic watchdog_timeout_flag;
  logic watchdog_clear;
  logic irq;
  int err_total = 0; // mismatches
  int num_checks = 0; // comparisons made
  int cycles = 0; // hang guard
  logic [7:0] d; // last read value
  logic [7:0] v; // last written control value
  logic [2:0] sel; // select code: drawn fast, or slow in one halt pass
  op_mode_e halt_mode; // expected halt mode
  op_mode_e back_mode; // expected mode after wake
  // ----------------------------------------------------------------
  // design, short oscillator start (100 cycles each)
  // ----------------------------------------------------------------
  operating_mode_clock_controller #(
    .HS_START_NS(2000),
    .LS_START_NS(2000),
    .CNT_W(16)
  ) dut (
    .clock(clock),
    .reset(reset),
    .bus_req(bus_req),
    .rdata(rdata),
    .clk_gate(clk_gate),
    .op_mode(op_mode),
    .powerdown_flag(powerdown_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .watchdog_clear(watchdog_clear),
    .irq(irq)
  );
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  // half period of 10 ns
  always #10 clock = ~clock;
  // cut a hang short after a generous cycle budget
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // tasks and functions
  // ----------------------------------------------------------------
  // compare seen against expected, count and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] wv);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.wdata <= wv;
    bus_req.write <= 1'b1;
    @(posedge clock);
    bus_req.write <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] rv);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.read <= 1'b1;
    @(posedge clock);
    bus_req.read <= 1'b0;
    #1 rv = rdata;
  endtask
  // software polls the stable flag, bounded
  task automatic wait_hs();
    logic [7:0] f;
    f = 8'h00;
    for (int n = 0; n < 300 && f[1] !== 1'b1; n++) begin
      rd(`ADDR_HS_OSC_CONTROL, f);
    end
  endtask
  // wait until the select in force equals the code, settled values
  task automatic wait_sel(input logic [2:0] c);
    #1;
    for (int n = 0; n < 400 && clk_gate.sysclk_select !== c; n++) begin
      @(posedge clock);
      #1;
    end
  endtask
  // halt mode for keep-on bits {hs, ls}
  function automatic op_mode_e exp_mode(input logic [1:0] k);
    case (k)
      2'b00: return mode_sleep;
      2'b01: return mode_idle_lowspeed_only;
      2'b10: return mode_idle_highspeed_only;
      default: return mode_idle_both_clocks;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    bus_req = '0;
    void'($urandom(32'hc036_d32f));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    // reset values
    rd(`ADDR_SYSCLK_CONTROL, d);
    chk(d, 8'h00);
    chk(8'(op_mode), 8'(mode_fast));
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h01);
    wait_hs();
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h03);
    // unused bits and read-only flag ignore writes
    wr(`ADDR_HS_OSC_CONTROL, 8'(($urandom() & 8'hfc) | 8'h01));
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h03);
    // unmapped index reads zero
    rd(4'h8 + 4'($urandom_range(7)), d);
    chk(d, 8'h00);
    // every select code, slow last
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_SYSCLK_CONTROL, {3'(c), 5'h00});
      wait_sel(3'(c));
      chk(8'(clk_gate.sysclk_select), 8'(c));
      chk(8'(op_mode), 8'((c == 7) ? mode_slow : mode_fast));
    end
    rd(`ADDR_MODE_STATUS, d);
    chk(d, 8'he7);
    // slow mode, oscillator disabled and unneeded
    wr(`ADDR_HS_OSC_CONTROL, 8'h00);
    for (int n = 0; n < 50 && clk_gate.hs_osc_on !== 1'b0; n++) begin
      @(posedge clock);
    end
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h00);
    // re-enable: flag low first, then stable
    wr(`ADDR_HS_OSC_CONTROL, 8'h01);
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h01);
    wait_hs();
    rd(`ADDR_HS_OSC_CONTROL, d);
    chk(d, 8'h03);
    // back to fast mode
    sel = 3'($urandom_range(6));
    wr(`ADDR_SYSCLK_CONTROL, {sel, 5'h00});
    wait_sel(sel);
    chk(8'(op_mode), 8'(mode_fast));
    // halt entry for every keep-on combination, reset before each
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd(`ADDR_HS_OSC_CONTROL, d);
      chk(d, 8'h01);
      // one pass halts from slow mode
      sel = (k == 2) ? `SEL_LOWSPEED : 3'($urandom_range(6));
      v = {sel, 3'h0, 2'(k)};
      halt_mode = exp_mode(2'(k));
      back_mode = (sel == `SEL_LOWSPEED) ? mode_slow : mode_fast;
      wr(`ADDR_SYSCLK_CONTROL, v);
      wait_hs();
      wait_sel(sel);
      chk(8'(powerdown_flag), 8'h00);
      wr(`ADDR_IRQ_ENABLE, {7'h00, k != 0});
      wr(`ADDR_IRQ_CLEAR, 8'h07);
      wr(`ADDR_HALT_CMD, 8'($urandom()));
      #1 chk(8'(op_mode), 8'(halt_mode));
      chk(8'(clk_gate.cpu_run), 8'h00);
      chk(8'(clk_gate.sys_clk_run), 8'h00);
      chk({6'h00, powerdown_flag, watchdog_timeout_flag}, 8'h02);
      chk(8'(watchdog_clear), 8'h01);
      @(posedge clock);
      #1 chk(8'(watchdog_clear), 8'h00);
      chk(8'(clk_gate.hs_osc_on), 8'(k[1]));
      chk(8'(clk_gate.ls_osc_on), 8'(k[0]));
      chk(8'(irq), 8'(k != 0));
      rd(`ADDR_IRQ_STATUS, d);
      chk(d, 8'h01);
      rd(`ADDR_IRQ_ENABLE, d);
      chk(d, 8'(k != 0));
      // second halt while halted is refused
      wr(`ADDR_HALT_CMD, 8'h00);
      #1 chk(8'(op_mode), 8'(halt_mode));
      chk(8'(watchdog_clear), 8'h00);
      rd(`ADDR_SYSCLK_CONTROL, d);
      chk(d, v);
      wr(`ADDR_WAKE_CMD, 8'h00);
      #1;
      for (int n = 0; n < 400 && op_mode !== back_mode; n++) begin
        @(posedge clock);
        #1;
      end
      chk(8'(op_mode), 8'(back_mode));
      wr(`ADDR_IRQ_CLEAR, 8'h01);
      repeat (2) @(posedge clock);
      #1 chk(8'(irq), 8'h00);
    end
    end_sim();
  end
endmodule
